//--- src/bta_pkg.sv
`default_nettype none

package bta_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_BR = 4;
  localparam int MV_W   = 16;
  localparam int MA_W   = 16;
  localparam int TC_W   = 8;
  localparam int MS_W   = 8;

  // ==========================================================
  // fixed thresholds
  localparam logic [MV_W-1:0] OVP_TRIP_MV  = 16'h7080;  // 28.8 V
  localparam logic [MA_W-1:0] TRIP_MIN_MA  = 16'h01F4;  // 0.5 A
  localparam logic [MA_W-1:0] TRIP_MAX_MA  = 16'h0ED8;  // 3.8 A
  localparam logic [MA_W-1:0] FIXED_TRIP_MA = 16'h0FA0; // 4.0 A
  localparam logic [TC_W-1:0] TEMP_HYST_C  = 8'h03;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYC_DEF  = TICK_NS / CLK_PERIOD_NS;
  localparam int STD_TRIP_MS   = 100;
  localparam int INST_TRIP_MS  = 20;
  localparam int STD_DET_MS    = 80;
  localparam int INST_DET_MS   = 10;
  localparam int INRUSH_MS     = 70;
  localparam logic [MS_W-1:0] STD_DET_TICKS  = MS_W'(STD_DET_MS);
  localparam logic [MS_W-1:0] INST_DET_TICKS = MS_W'(INST_DET_MS);
  localparam logic [MS_W-1:0] INRUSH_TICKS   = MS_W'(INRUSH_MS);

  // ==========================================================
  // types
  // larger code = more severe
  typedef enum logic [1:0] {
    ERR_NONE  = 2'b00,
    ERR_OC    = 2'b01,
    ERR_FIXED = 2'b10,
    ERR_OVP   = 2'b11
  } bta_err_t;

  typedef struct packed {
    logic [MV_W-1:0]             volt_mv;
    logic [NUM_BR-1:0][MA_W-1:0] curr_ma;
    logic [TC_W-1:0]             temp_c;
  } bta_meas_t;

  typedef struct packed {
    logic [MV_W-1:0]             uv_alarm_mv;
    logic [MV_W-1:0]             ov_alarm_mv;
    logic [MA_W-1:0]             oc_alarm_ma;
    logic [NUM_BR-1:0][MA_W-1:0] trip_ma;
    logic [NUM_BR-1:0]           inst_mode;
    logic [NUM_BR-1:0]           branch_en;
    logic [TC_W-1:0]             ot_limit_c;
    logic                        redundant_en;
  } bta_cfg_t;

endpackage

`default_nettype wire

//--- src/bta_trip_alarm.sv
`timescale 1ns/1ps
`default_nettype none

module bta_trip_alarm
  import bta_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic              ce_in,
  input  wire bta_meas_t         meas_in,
  input  wire bta_cfg_t          cfg_in,
  input  wire logic              runtime_over_in,
  input  wire logic              reset_op_in,
  input  wire logic              nv_trip_in,
  input  wire logic              nv_alarm_in,
  output var  logic [NUM_BR-1:0] relay_on_out,
  output var  logic              trip_alarm_out,
  output var  logic              general_alarm_out,
  output var  logic              overtemp_out,
  output var  bta_err_t          err_code_out,
  output var  logic              err_req_out,
  output var  logic              nv_trip_out,
  output var  logic              nv_alarm_out
);

  localparam int TICK_W = $clog2(TICK_CYC);

  // ==========================================================
  // reset operation sync and millisecond tick
  logic [2:0]        rop_q, rop_d;
  logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic              init_q, init_d;
  logic              tick;
  logic              rst_op;

  assign tick   = (tick_cnt_q == TICK_W'(TICK_CYC - 1));
  // held key counts once
  assign rst_op = rop_q[1] & ~rop_q[2];

  always_comb begin
    rop_d      = {rop_q[1:0], reset_op_in};
    tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
    init_d     = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rop_q      <= 3'h0;
      tick_cnt_q <= '0;
      init_q     <= 1'b1;
    end else if (ce_in) begin
      rop_q      <= rop_d;
      tick_cnt_q <= tick_cnt_d;
      init_q     <= init_d;
    end
  end

  // ==========================================================
  // per-branch trip logic
  logic [NUM_BR-1:0]           br_trip_q, br_trip_d;
  logic [NUM_BR-1:0]           relay_q, relay_d;
  logic [NUM_BR-1:0][MS_W-1:0] oc_cnt_q, oc_cnt_d;
  logic [NUM_BR-1:0][MS_W-1:0] blank_q, blank_d;
  logic [NUM_BR-1:0][MA_W-1:0] eff_trip;
  logic [NUM_BR-1:0]           over_set, over_fixed, oc_trip, blanked;
  logic [MS_W-1:0]             det;
  logic                        ovp;
  bta_err_t                    cause;

  assign ovp = meas_in.volt_mv > OVP_TRIP_MV;

  always_comb begin
    cause = ovp ? ERR_OVP : ERR_NONE;
    det   = STD_DET_TICKS;
    for (int i = 0; i < NUM_BR; i++) begin
      if (cfg_in.trip_ma[i] < TRIP_MIN_MA) begin
        eff_trip[i] = TRIP_MIN_MA;
      end else if (cfg_in.trip_ma[i] > TRIP_MAX_MA) begin
        eff_trip[i] = TRIP_MAX_MA;
      end else begin
        eff_trip[i] = cfg_in.trip_ma[i];
      end
      blanked[i]    = blank_q[i] != '0;
      over_set[i]   = meas_in.curr_ma[i] > eff_trip[i];
      over_fixed[i] = cfg_in.redundant_en && (meas_in.curr_ma[i] > FIXED_TRIP_MA)
                      && !blanked[i];
      det = cfg_in.inst_mode[i] ? INST_DET_TICKS : STD_DET_TICKS;
      if (!over_set[i] || blanked[i]) begin
        oc_cnt_d[i] = '0;
      end else if (tick && (oc_cnt_q[i] < det)) begin
        oc_cnt_d[i] = oc_cnt_q[i] + 1'b1;
      end else begin
        oc_cnt_d[i] = oc_cnt_q[i];
      end
      oc_trip[i] = over_set[i] && !blanked[i] && (oc_cnt_q[i] >= det);
      // latched until reset, new event wins
      br_trip_d[i] = ovp || over_fixed[i] || oc_trip[i] || (br_trip_q[i] && !rst_op);
      relay_d[i]   = cfg_in.branch_en[i] && !br_trip_d[i];
      if (!relay_d[i]) begin
        blank_d[i] = '0;
      end else if (!relay_q[i]) begin
        blank_d[i] = INRUSH_TICKS;
      end else if (tick && blanked[i]) begin
        blank_d[i] = blank_q[i] - 1'b1;
      end else begin
        blank_d[i] = blank_q[i];
      end
      if (over_fixed[i] && (cause < ERR_FIXED)) begin
        cause = ERR_FIXED;
      end else if (oc_trip[i] && (cause < ERR_OC)) begin
        cause = ERR_OC;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      br_trip_q <= '0;
      relay_q   <= '0;
      oc_cnt_q  <= '0;
      blank_q   <= '0;
    end else if (ce_in) begin
      br_trip_q <= br_trip_d;
      relay_q   <= relay_d;
      oc_cnt_q  <= oc_cnt_d;
      blank_q   <= blank_d;
    end
  end

  // ==========================================================
  // status outputs
  logic              tripped_q, tripped_d;
  logic              trip_alarm_q, trip_alarm_d;
  logic              alarm_q, alarm_d;
  logic              ot_q, ot_d;
  bta_err_t          err_q, err_d;
  logic              req_q, req_d;
  logic              alarm_cond, new_trip;
  logic [NUM_BR-1:0] oc_alarm;
  logic [TC_W:0]     temp_hyst;

  always_comb begin
    for (int i = 0; i < NUM_BR; i++) begin
      oc_alarm[i] = meas_in.curr_ma[i] > cfg_in.oc_alarm_ma;
    end
    alarm_cond = (meas_in.volt_mv < cfg_in.uv_alarm_mv)
              || (meas_in.volt_mv > cfg_in.ov_alarm_mv)
              || (|oc_alarm) || runtime_over_in;
    new_trip   = cause != ERR_NONE;
    // restored at power-up, cleared only by reset operation
    if (init_q) begin
      tripped_d = nv_trip_in || new_trip;
    end else begin
      tripped_d = new_trip || (tripped_q && !rst_op);
    end
    // trip alarm output off while tripped
    trip_alarm_d = !tripped_d;
    // most severe cause kept for display
    if (new_trip && (cause > err_q)) begin
      err_d = cause;
    end else if (rst_op && !new_trip) begin
      err_d = ERR_NONE;
    end else begin
      err_d = err_q;
    end
    req_d = new_trip && (cause > err_q);
    // kept alarm drops at power-up when cause gone
    if (init_q) begin
      alarm_d = nv_alarm_in && alarm_cond;
    end else begin
      alarm_d = alarm_cond || (alarm_q && !rst_op);
    end
    // set above limit, release 3 below
    temp_hyst = {1'b0, meas_in.temp_c} + {1'b0, TEMP_HYST_C};
    ot_d      = (meas_in.temp_c > cfg_in.ot_limit_c)
             || (ot_q && (temp_hyst > {1'b0, cfg_in.ot_limit_c}));
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tripped_q    <= 1'b0;
      trip_alarm_q <= 1'b1;
      alarm_q      <= 1'b0;
      ot_q         <= 1'b0;
      err_q        <= ERR_NONE;
      req_q        <= 1'b0;
    end else if (ce_in) begin
      tripped_q    <= tripped_d;
      trip_alarm_q <= trip_alarm_d;
      alarm_q      <= alarm_d;
      ot_q         <= ot_d;
      err_q        <= err_d;
      req_q        <= req_d;
    end
  end

  assign relay_on_out      = relay_q;
  assign trip_alarm_out    = trip_alarm_q;
  assign general_alarm_out = alarm_q;
  assign overtemp_out      = ot_q;
  assign err_code_out      = err_q;
  assign err_req_out       = req_q;
  assign nv_trip_out       = tripped_q;
  assign nv_alarm_out      = alarm_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_live;
    ce_in && !init_q;
  endsequence

  a_ovp_cut_all: assert property (s_live and ovp |=> relay_on_out == '0)
    else $error("overvoltage did not cut all branches");
  a_trip_alarm_off: assert property (|br_trip_q |-> !trip_alarm_out)
    else $error("branch tripped while trip alarm output on");
  a_trip_held: assert property (tripped_q && !(ce_in && rst_op) |=> tripped_q)
    else $error("trip alarm left without reset operation");
  a_err_request: assert property (s_live and ovp && err_q != ERR_OVP
                                  |=> err_req_out && err_code_out == ERR_OVP)
    else $error("no error code request on overvoltage trip");
  a_alarm_set: assert property (s_live and alarm_cond |=> general_alarm_out)
    else $error("general alarm not raised");
  a_alarm_clear: assert property (s_live and rst_op && !alarm_cond
                                  |=> !general_alarm_out)
    else $error("reset operation did not clear alarm");
  a_alarm_boot: assert property (ce_in && init_q && !alarm_cond
                                 |=> !general_alarm_out)
    else $error("stale alarm kept at power-up");
  a_ot_set: assert property (ce_in && meas_in.temp_c > cfg_in.ot_limit_c
                             |=> overtemp_out)
    else $error("over-temperature not flagged");
  a_ot_hold: assert property (ce_in && ot_q && temp_hyst > {1'b0, cfg_in.ot_limit_c}
                              |=> overtemp_out)
    else $error("over-temperature released inside hysteresis");

  for (genvar g = 0; g < NUM_BR; g++) begin : g_chk
    a_trip_clamp: assert property (eff_trip[g] >= TRIP_MIN_MA
                                   && eff_trip[g] <= TRIP_MAX_MA)
      else $error("trip value outside range");
    a_fixed_cut: assert property (ce_in && over_fixed[g] |=> !relay_on_out[g])
      else $error("fixed path did not cut branch");
    a_oc_cut: assert property (ce_in && over_set[g] && !blanked[g]
                               && oc_cnt_q[g] >= INST_DET_TICKS && cfg_in.inst_mode[g]
                               |=> br_trip_q[g])
      else $error("instantaneous trip late");
    a_inrush_quiet: assert property (ce_in && blanked[g] && !ovp && !br_trip_q[g]
                                     |=> !br_trip_q[g])
      else $error("current trip during inrush blanking");
    a_branch_latch: assert property (br_trip_q[g] && !(ce_in && rst_op)
                                     |=> br_trip_q[g] && !relay_on_out[g])
      else $error("tripped branch reconnected without reset");
    a_count_bound: assert property (oc_cnt_q[g] <= STD_DET_TICKS)
      else $error("duration counter overran");
  end

endmodule

`default_nettype wire

//--- verification/bta_load_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// branch loads: a cut branch draws nothing
module bta_load_model
  import bta_pkg::*;
(
  input  wire logic                        clk_in,
  input  wire logic [NUM_BR-1:0]           relay_on_in,
  input  wire logic [NUM_BR-1:0][MA_W-1:0] demand_ma_in,
  output var  logic [NUM_BR-1:0][MA_W-1:0] curr_ma_out
);
  // one cycle of sensor lag, as a real front end has
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < NUM_BR; i++) begin
      curr_ma_out[i] <= relay_on_in[i] ? demand_ma_in[i] : 16'h0000;
    end
  end
endmodule

`default_nettype wire

//--- verification/branch_trip_alarm_logic_test.sv
`timescale 1ns/1ps
`default_nettype none

module branch_trip_alarm_logic_test import bta_pkg::*; ;
  // ==========================================================
  // signals
  localparam int TCK = 10;
  logic                        clk_in = 1'b0;
  logic                        srst, rt_over, rop, nvt_in, nva_in;
  logic [MV_W-1:0]             volt;
  logic [TC_W-1:0]             temp;
  logic [NUM_BR-1:0][MA_W-1:0] demand, curr;
  bta_cfg_t                    cfg;
  bta_meas_t                   meas;
  logic [NUM_BR-1:0]           relay;
  logic                        trip_al, gen_al, ot, err_req, nvt_out, nva_out;
  bta_err_t                    err;
  int                          n_errors = 0;
  int                          n_checks = 0;

  always #4 clk_in = ~clk_in;
  always_comb meas = '{volt_mv: volt, curr_ma: curr, temp_c: temp};

  bta_trip_alarm #(.TICK_CYC(TCK)) DUT (
    .clk_in(clk_in), .srst_in(srst), .ce_in(1'b1), .meas_in(meas), .cfg_in(cfg),
    .runtime_over_in(rt_over), .reset_op_in(rop), .nv_trip_in(nvt_in),
    .nv_alarm_in(nva_in), .relay_on_out(relay), .trip_alarm_out(trip_al),
    .general_alarm_out(gen_al), .overtemp_out(ot), .err_code_out(err),
    .err_req_out(err_req), .nv_trip_out(nvt_out), .nv_alarm_out(nva_out));

  bta_load_model LOAD (.clk_in(clk_in), .relay_on_in(relay), .demand_ma_in(demand),
    .curr_ma_out(curr));

  // ==========================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic press_rop;
    step(1);
    rop <= 1'b1;
    step(3);
    rop <= 1'b0;
    #1;
  endtask

  task automatic do_reset(input logic t, input logic a);
    step(1);
    srst   <= 1'b1;
    nvt_in <= t;
    nva_in <= a;
    step(5);
    srst <= 1'b0;
    step(3);
    #1;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_temp;
    step(1);
    temp <= 8'h3C;
    step(3); #1 chk(ot, 1'b0, "ot at limit");
    temp <= 8'h3D;
    step(2); #1 chk(ot, 1'b1, "ot set");
    temp <= 8'h3A;
    step(2); #1 chk(ot, 1'b1, "ot hyst");
    temp <= 8'h39;
    step(2); #1 chk(ot, 1'b0, "ot release");
    $display("temp done");
  endtask

  task automatic t_ovp;
    step(1);
    volt <= 16'h7080;
    step(3); #1 chk(relay, 4'hF, "ovp edge");
    volt <= 16'h7081;
    step(1); #1 chk(relay, 4'h0, "ovp cut");
    chk(trip_al, 1'b0, "ovp trp");
    chk({2'b00, err}, 4'h3, "ovp code");
    chk(err_req, 1'b1, "ovp req");
    chk(nvt_out, 1'b1, "ovp nv");
    volt <= 16'h5DC0;
    step(1); #1 chk(err_req, 1'b0, "req pulse");
    step(5); #1 chk(relay, 4'h0, "ovp held");
    chk(trip_al, 1'b0, "trp held");
    press_rop;
    chk(relay, 4'hF, "rop relay");
    chk(trip_al, 1'b1, "rop trp");
    chk(nvt_out, 1'b0, "rop nv");
    chk({2'b00, err}, 4'h0, "rop code");
    $display("ovp done");
  endtask

  task automatic t_std;
    step(720);
    cfg.redundant_en <= 1'b0;
    cfg.trip_ma[1]   <= 16'hFFFF;
    demand[1]        <= 16'h0F3C;
    step(790); #1 chk(relay, 4'hF, "std early");
    step(40); #1 chk(relay, 4'hD, "std cut");
    chk({2'b00, err}, 4'h1, "std code");
    demand[1] <= 16'h0064;
    cfg.trip_ma[1] <= 16'h03E8;
    cfg.redundant_en <= 1'b1;
    step(20); #1 chk(relay, 4'hD, "std held");
    press_rop;
    $display("std done");
  endtask

  task automatic t_inst;
    step(720);
    cfg.inst_mode[0] <= 1'b1;
    cfg.trip_ma[0]   <= 16'h0064;
    demand[0]        <= 16'h0190;
    step(200); #1 chk(relay, 4'hF, "clamp low");
    demand[0] <= 16'h0258;
    // tenth tick can land as early as 92 cycles after the step
    step(90); #1 chk(relay, 4'hF, "inst early");
    step(35); #1 chk(relay, 4'hE, "inst cut");
    cfg.inst_mode[0] <= 1'b0;
    cfg.trip_ma[0]   <= 16'h03E8;
    demand[0]        <= 16'h0064;
    press_rop;
    $display("inst done");
  endtask

  task automatic t_inrush;
    // reconnect branch 3 so its blanking window starts now
    step(1);
    cfg.branch_en[3] <= 1'b0;
    step(2);
    cfg.branch_en[3] <= 1'b1;
    demand[3] <= 16'h0FA1;
    step(600); #1 chk(relay, 4'hF, "blanked");
    step(130); #1 chk(relay, 4'h7, "fixed cut");
    chk({2'b00, err}, 4'h2, "fixed code");
    demand[3] <= 16'h0064;
    press_rop;
    $display("inrush done");
  endtask

  task automatic t_alarm;
    for (int k = 0; k < 4; k++) begin
      step(1);
      case (k)
        0: volt <= 16'h4000;
        1: volt <= 16'h6E00;
        2: cfg.oc_alarm_ma <= 16'h0050;
        default: rt_over <= 1'b1;
      endcase
      step(3); #1 chk(gen_al, 1'b1, "alarm set");
      chk(nva_out, 1'b1, "alarm nv");
      volt <= 16'h5DC0;
      cfg.oc_alarm_ma <= 16'h0FFF;
      rt_over <= 1'b0;
      step(3); #1 chk(gen_al, 1'b1, "alarm held");
      press_rop;
      chk(gen_al, 1'b0, "alarm clr");
      chk(nva_out, 1'b0, "alarm nv clr");
    end
    $display("alarm done");
  endtask

  task automatic t_powerup;
    do_reset(1'b1, 1'b1);
    chk(gen_al, 1'b0, "pwr alarm gone");
    chk(trip_al, 1'b0, "pwr trp kept");
    rt_over <= 1'b1;
    do_reset(1'b0, 1'b1);
    chk(gen_al, 1'b1, "pwr alarm kept");
    chk(trip_al, 1'b1, "pwr trp clr");
    rt_over <= 1'b0;
    $display("powerup done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    srst = 1'b1; rt_over = 1'b0; rop = 1'b0; nvt_in = 1'b0; nva_in = 1'b0;
    volt = 16'h5DC0; temp = 8'h19;
    demand = {NUM_BR{16'h0064}};
    cfg = '{uv_alarm_mv: 16'h4650, ov_alarm_mv: 16'h6D60, oc_alarm_ma: 16'h0FFF,
            trip_ma: {NUM_BR{16'h03E8}}, inst_mode: 4'h0, branch_en: 4'hF,
            ot_limit_c: 8'h3C, redundant_en: 1'b1};
    do_reset(1'b0, 1'b0);
    chk(trip_al, 1'b1, "rst trp");
    chk(gen_al, 1'b0, "rst alarm");
    t_temp;
    t_ovp;
    t_std;
    t_inst;
    t_inrush;
    t_alarm;
    t_powerup;
    final_report;
  end

  // roughly five times the expected run length
  initial begin
    #150000;
    n_errors++;
    final_report;
  end
endmodule

`default_nettype wire
